// ### hdl/tlb_pkg.sv
// constants of the t1 link byte path and the loop-code logic.
// assumes an 8-bit register port and line strobes synchronous to clk.
// Notes on behaviour
// - receive link bits shift into byte register
// - full byte sets flag, masked interrupt
// - byte equal to either compare sets match
// - first received bit lands in lsb
// - destuff removes zero after five ones
// - zero after six ones stays
// - transmit byte goes out lsb first
// - eight bits sent sets empty flag
// - no new byte means resend old
// - stuffing inserts zero after five ones
// - one transmit source, receive shared
// - loop enable sends pattern continuously
// - framing bit overwrites pattern every frame
// - separate up and down detectors
// - three-bit field gives n+1 length
// - detect framed or unframed, 1e-2 errors
// - status set after 48 ms integration
package tlb_pkg;
  localparam logic [7:0] ADDR_LEN_CTRL  = 8'h12;
  localparam logic [7:0] ADDR_TX_PAT    = 8'h13;
  localparam logic [7:0] ADDR_UP_PAT    = 8'h14;
  localparam logic [7:0] ADDR_DN_PAT    = 8'h15;
  localparam logic [7:0] ADDR_RX_BYTE   = 8'h28;
  localparam logic [7:0] ADDR_CMP_A     = 8'h29;
  localparam logic [7:0] ADDR_CMP_B     = 8'h2A;
  localparam logic [7:0] ADDR_TX_BYTE   = 8'h7E;
  localparam logic [7:0] ADDR_CTRL      = 8'h60;
  localparam logic [7:0] ADDR_STATUS    = 8'h61;
  localparam logic [7:0] ADDR_MASK      = 8'h62;
  // control register fields
  localparam int CTL_DESTUFF = 0;
  localparam int CTL_TX_LOOP_CODE_ENABLE   = 1;
  localparam int CTL_FSRC    = 2;
  localparam int CTL_LEGACY  = 3;
  localparam int CTL_STUFF   = 4;
  localparam int CTL_MFLOAD  = 5;
  // status and mask fields
  localparam int ST_MATCH = 2;
  localparam int ST_EMPTY = 3;
  localparam int ST_FULL  = 4;
  localparam int ST_DOWN  = 6;
  localparam int ST_UP    = 7;
  localparam logic [7:0] LATCHED_MASK = 8'h1C;
  // length control fields
  localparam int LEN_TX_MSB = 7;
  localparam int LEN_UP_MSB = 5;
  localparam int LEN_DN_MSB = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_CTRL = 8'h00;
  // integration time and error tolerance
  localparam int CLK_HZ        = 100_000_000;
  localparam int INTEG_MS      = 48;
  localparam int INTEG_CYCLES  = INTEG_MS * (CLK_HZ / 1000);
  localparam int ERR_RATIO     = 100;
  localparam int ONES_BEFORE_STUFF = 5;
endpackage

// ### hdl/tlb_det_if.sv
// signals between the register side and one loop-code detector.
// assumes the detector runs on the same clock as its user.
`timescale 1ns/1ps
interface tlb_det_if;
  logic [7:0] pattern;
  logic [2:0] len_field;
  logic       line_bit;
  logic       line_stb;
  logic       detected;
  modport ctrl (output pattern, output len_field, output line_bit, output line_stb,
                input detected);
  modport det  (input pattern, input len_field, input line_bit, input line_stb,
                output detected);
endinterface

// ### hdl/tlb_loop_det.sv
// one repeating-code detector with error-tolerant integration.
// assumes line strobes synchronous to clk, one bit per strobe.
`timescale 1ns/1ps
module tlb_loop_det #(
  parameter int INTEG_CYCLES = tlb_pkg::INTEG_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // detector link
  tlb_det_if.det    dif
);
  logic [7:0]  hist_q;
  logic [7:0]  hist_d;
  logic [2:0]  ptr_q;
  logic [2:0]  len_m1;
  logic [22:0] cyc_q;
  logic [22:0] bits_q;
  logic [22:0] errs_q;
  logic        det_q;
  logic        exact;
  logic        expect_bit;
  logic        win_end;
  logic [29:0] err_scaled;

  assign len_m1     = dif.len_field;
  assign hist_d     = {hist_q[6:0], dif.line_bit};
  assign expect_bit = dif.pattern[3'd7 - ptr_q];
  assign win_end    = (cyc_q == 23'(INTEG_CYCLES - 1));
  assign err_scaled = 30'(errs_q) * 30'(tlb_pkg::ERR_RATIO);
  assign dif.detected = det_q;

  // last n+1 bits, oldest first, against the head of the pattern
  always_comb begin
    exact = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i <= int'(len_m1) && hist_d[len_m1 - 3'(i)] != dif.pattern[7 - i]) begin
        exact = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hist_q <= 8'h00;
      ptr_q  <= 3'h0;
    end else if (dif.line_stb) begin
      hist_q <= hist_d;
      // resync on an exact window, works framed or unframed
      if (exact || ptr_q >= len_m1) begin
        ptr_q <= 3'h0;
      end else begin
        ptr_q <= ptr_q + 3'h1;
      end
    end
  end

  // fixed window so the answer settles after the nominal integration
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cyc_q  <= 23'h000000;
      bits_q <= 23'h000000;
      errs_q <= 23'h000000;
      det_q  <= 1'b0;
    end else if (win_end) begin
      cyc_q  <= 23'h000000;
      bits_q <= 23'h000000;
      errs_q <= 23'h000000;
      det_q  <= (bits_q != 23'h000000) && (err_scaled <= 30'(bits_q));
    end else begin
      cyc_q <= cyc_q + 23'h000001;
      if (dif.line_stb) begin
        bits_q <= bits_q + 23'h000001;
        if (!exact && dif.line_bit != expect_bit) begin
          errs_q <= errs_q + 23'h000001;
        end
      end
    end
  end
endmodule

// ### hdl/tlb_core.sv
// legacy link byte path plus loop-code generator and detectors.
// assumes line strobes come from the framer, synchronous to clk.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module tlb_core #(
  parameter int INTEG_CYCLES = tlb_pkg::INTEG_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            int_n,
  // receive link bits
  input  wire logic       rx_link_bit,
  input  wire logic       rx_link_stb,
  // receive line bits for the detectors
  input  wire logic       rx_line_bit,
  input  wire logic       rx_line_stb,
  // transmit link slots
  input  wire logic       tx_link_req,
  input  wire logic       tx_mf_boundary,
  output logic            tx_link_bit,
  output logic            tx_link_legacy,
  output logic            tx_fs_from_link,
  // transmit loop code
  input  wire logic       tx_line_stb,
  input  wire logic       tx_fbit_pos,
  input  wire logic       tx_fbit_val,
  input  wire logic       tx_fbit_off,
  output logic            tx_code_bit,
  output logic            tx_code_active
);
  // host registers
  logic [7:0] len_ctrl_q;
  logic [7:0] tx_pat_q;
  logic [7:0] up_pat_q;
  logic [7:0] dn_pat_q;
  logic [7:0] rx_link_byte_q;
  logic [7:0] cmp_a_q;
  logic [7:0] cmp_b_q;
  logic [7:0] tx_link_byte_q;
  logic [7:0] ctrl_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] mask_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       int_n_q;
  logic       fs_from_link_q;

  // decode
  logic wr_len;
  logic wr_txp;
  logic wr_up;
  logic wr_dn;
  logic wr_cmpa;
  logic wr_cmpb;
  logic wr_txb;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_status;

  assign wr_len    = reg_wr && reg_addr == tlb_pkg::ADDR_LEN_CTRL;
  assign wr_txp    = reg_wr && reg_addr == tlb_pkg::ADDR_TX_PAT;
  assign wr_up     = reg_wr && reg_addr == tlb_pkg::ADDR_UP_PAT;
  assign wr_dn     = reg_wr && reg_addr == tlb_pkg::ADDR_DN_PAT;
  assign wr_cmpa   = reg_wr && reg_addr == tlb_pkg::ADDR_CMP_A;
  assign wr_cmpb   = reg_wr && reg_addr == tlb_pkg::ADDR_CMP_B;
  assign wr_txb    = reg_wr && reg_addr == tlb_pkg::ADDR_TX_BYTE;
  assign wr_ctrl   = reg_wr && reg_addr == tlb_pkg::ADDR_CTRL;
  assign wr_mask   = reg_wr && reg_addr == tlb_pkg::ADDR_MASK;
  assign rd_status = reg_rd && reg_addr == tlb_pkg::ADDR_STATUS;

  // receive path state
  logic [7:0] rx_sr_q;
  logic [2:0] rx_cnt_q;
  logic [2:0] rx_ones_q;
  logic       rx_drop;
  logic [7:0] rx_sr_next;
  logic       rx_done;
  logic       rx_match;

  // transmit path state
  logic [7:0] tx_sr_q;
  logic [2:0] tx_cnt_q;
  logic [2:0] tx_ones_q;
  logic       tx_stuff_q;
  logic       tx_bit_q;
  logic       tx_cur;
  logic       tx_done;
  logic       tx_mf_load;

  // loop-code generator state
  logic [2:0] gen_ptr_q;
  logic [2:0] gen_last;
  logic       gen_bit_q;
  logic       gen_pat_bit;

  // detectors
  logic [1:0] det_hit;
  tlb_det_if det_if[2] ();

  // receive: destuff, then assemble lsb first
  assign rx_drop = ctrl_q[tlb_pkg::CTL_DESTUFF] && !rx_link_bit
                   && rx_ones_q == 3'(tlb_pkg::ONES_BEFORE_STUFF);
  assign rx_sr_next = {rx_link_bit, rx_sr_q[7:1]};
  assign rx_done  = rx_link_stb && !rx_drop && rx_cnt_q == 3'h7;
  assign rx_match = rx_sr_next == cmp_a_q || rx_sr_next == cmp_b_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_sr_q   <= tlb_pkg::RESET_BYTE;
      rx_cnt_q  <= 3'h0;
      rx_ones_q <= 3'h0;
    end else if (rx_link_stb) begin
      // six or more ones saturate so a flag zero is never removed
      if (!rx_link_bit) begin
        rx_ones_q <= 3'h0;
      end else if (rx_ones_q != 3'h6) begin
        rx_ones_q <= rx_ones_q + 3'h1;
      end
      if (!rx_drop) begin
        rx_sr_q  <= rx_sr_next;
        rx_cnt_q <= rx_cnt_q + 3'h1;
      end
    end
  end

  // unread byte is simply overwritten by the next one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_link_byte_q <= tlb_pkg::RESET_BYTE;
    end else if (rx_done) begin
      rx_link_byte_q <= rx_sr_next;
    end
  end

  // transmit: lsb first, optional zero insertion
  assign tx_cur     = tx_sr_q[0];
  assign tx_mf_load = ctrl_q[tlb_pkg::CTL_MFLOAD] && tx_mf_boundary;
  assign tx_done    = tx_link_req && !tx_stuff_q && tx_cnt_q == 3'h7;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_sr_q    <= tlb_pkg::RESET_BYTE;
      tx_cnt_q   <= 3'h0;
      tx_ones_q  <= 3'h0;
      tx_stuff_q <= 1'b0;
      tx_bit_q   <= 1'b0;
    end else if (tx_mf_load) begin
      // framing byte realigns to the multiframe
      tx_sr_q  <= tx_link_byte_q;
      tx_cnt_q <= 3'h0;
    end else if (tx_link_req) begin
      if (tx_stuff_q) begin
        tx_bit_q   <= 1'b0;
        tx_stuff_q <= 1'b0;
        tx_ones_q  <= 3'h0;
      end else begin
        tx_bit_q  <= tx_cur;
        tx_cnt_q  <= tx_cnt_q + 3'h1;
        tx_ones_q <= tx_cur ? tx_ones_q + 3'h1 : 3'h0;
        tx_stuff_q <= ctrl_q[tlb_pkg::CTL_STUFF] && tx_cur
                      && tx_ones_q == 3'(tlb_pkg::ONES_BEFORE_STUFF - 1);
        // the held byte is reloaded, so an old value repeats
        tx_sr_q <= tx_done ? tx_link_byte_q : {1'b0, tx_sr_q[7:1]};
      end
    end
  end

  // loop-code generator
  always_comb begin
    case (len_ctrl_q[tlb_pkg::LEN_TX_MSB -: 2])
      2'b00:   gen_last = 3'h4;
      2'b01:   gen_last = 3'h5;
      2'b10:   gen_last = 3'h6;
      default: gen_last = 3'h7;
    endcase
  end
  assign gen_pat_bit = tx_pat_q[3'h7 - gen_ptr_q];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gen_ptr_q <= 3'h0;
      gen_bit_q <= 1'b0;
    end else if (!ctrl_q[tlb_pkg::CTL_TX_LOOP_CODE_ENABLE]) begin
      gen_ptr_q <= 3'h0;
    end else if (tx_line_stb) begin
      // pattern keeps counting under the framing bit
      gen_ptr_q <= gen_ptr_q >= gen_last ? 3'h0 : gen_ptr_q + 3'h1;
      gen_bit_q <= (tx_fbit_pos && !tx_fbit_off) ? tx_fbit_val : gen_pat_bit;
    end
  end

  // two detectors share one module
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_det
      assign det_if[g].pattern   = (g == 0) ? up_pat_q : dn_pat_q;
      assign det_if[g].len_field = (g == 0) ? len_ctrl_q[tlb_pkg::LEN_UP_MSB -: 3]
                                            : len_ctrl_q[tlb_pkg::LEN_DN_MSB -: 3];
      assign det_if[g].line_bit  = rx_line_bit;
      assign det_if[g].line_stb  = rx_line_stb;
      assign det_hit[g]          = det_if[g].detected;
      tlb_loop_det #(
        .INTEG_CYCLES (INTEG_CYCLES)
      ) u_det (
        .clk     (clk),
        .sys_rst (sys_rst),
        .dif     (det_if[g])
      );
    end
  endgenerate

  // latched flags: a set in the clearing cycle wins
  always_comb begin
    flags_d = flags_q;
    if (rd_status) begin
      flags_d = flags_q & ~tlb_pkg::LATCHED_MASK;
    end
    if (rx_done) begin
      flags_d[tlb_pkg::ST_FULL] = 1'b1;
    end
    if (rx_done && rx_match) begin
      flags_d[tlb_pkg::ST_MATCH] = 1'b1;
    end
    if (tx_done) begin
      flags_d[tlb_pkg::ST_EMPTY] = 1'b1;
    end
    flags_d[tlb_pkg::ST_UP]   = det_hit[0];
    flags_d[tlb_pkg::ST_DOWN] = det_hit[1];
  end

  // host register writes, one short block per register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      len_ctrl_q <= tlb_pkg::RESET_BYTE;
    end else if (wr_len) begin
      len_ctrl_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_pat_q <= tlb_pkg::RESET_BYTE;
    end else if (wr_txp) begin
      tx_pat_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      up_pat_q <= tlb_pkg::RESET_BYTE;
    end else if (wr_up) begin
      up_pat_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dn_pat_q <= tlb_pkg::RESET_BYTE;
    end else if (wr_dn) begin
      dn_pat_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmp_a_q <= tlb_pkg::RESET_BYTE;
    end else if (wr_cmpa) begin
      cmp_a_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmp_b_q <= tlb_pkg::RESET_BYTE;
    end else if (wr_cmpb) begin
      cmp_b_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_link_byte_q <= tlb_pkg::RESET_BYTE;
    end else if (wr_txb) begin
      tx_link_byte_q <= reg_wdata;
    end
  end

  // own flop for the framing source pin, so no inverter sits on the output
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q         <= tlb_pkg::RESET_CTRL;
      fs_from_link_q <= ~tlb_pkg::RESET_CTRL[tlb_pkg::CTL_FSRC];
    end else if (wr_ctrl) begin
      ctrl_q         <= reg_wdata;
      fs_from_link_q <= ~reg_wdata[tlb_pkg::CTL_FSRC];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q <= tlb_pkg::RESET_BYTE;
    end else if (wr_mask) begin
      mask_q <= reg_wdata;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      tlb_pkg::ADDR_LEN_CTRL: rdata_d = len_ctrl_q;
      tlb_pkg::ADDR_TX_PAT:   rdata_d = tx_pat_q;
      tlb_pkg::ADDR_UP_PAT:   rdata_d = up_pat_q;
      tlb_pkg::ADDR_DN_PAT:   rdata_d = dn_pat_q;
      tlb_pkg::ADDR_RX_BYTE:  rdata_d = rx_link_byte_q;
      tlb_pkg::ADDR_CMP_A:    rdata_d = cmp_a_q;
      tlb_pkg::ADDR_CMP_B:    rdata_d = cmp_b_q;
      tlb_pkg::ADDR_TX_BYTE:  rdata_d = tx_link_byte_q;
      tlb_pkg::ADDR_CTRL:     rdata_d = ctrl_q;
      tlb_pkg::ADDR_STATUS:   rdata_d = flags_q;
      tlb_pkg::ADDR_MASK:     rdata_d = mask_q;
      default:                rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_q <= 8'h00;
      rdata_q <= 8'h00;
      int_n_q <= 1'b1;
    end else begin
      flags_q <= flags_d;
      rdata_q <= reg_rd ? rdata_d : 8'h00;
      int_n_q <= ~|(flags_d & mask_q & tlb_pkg::LATCHED_MASK);
    end
  end

  assign reg_rdata       = rdata_q;
  assign int_n           = int_n_q;
  assign tx_link_bit     = tx_bit_q;
  assign tx_link_legacy  = ctrl_q[tlb_pkg::CTL_LEGACY];
  assign tx_fs_from_link = fs_from_link_q;
  assign tx_code_bit     = gen_bit_q;
  assign tx_code_active  = ctrl_q[tlb_pkg::CTL_TX_LOOP_CODE_ENABLE];
endmodule

// ### tb/tlb_core_sva.sv
// concurrent checks on the ports of the link byte and loop-code core.
// assumes a bind to tlb_core; it sees nothing but the core's ports.
`timescale 1ns/1ps
module tlb_core_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       int_n,
  // line side
  input wire logic       tx_link_req,
  input wire logic       tx_mf_boundary,
  input wire logic       tx_link_bit,
  input wire logic       tx_link_legacy,
  input wire logic       tx_fs_from_link,
  input wire logic       tx_line_stb,
  input wire logic       tx_fbit_pos,
  input wire logic       tx_fbit_val,
  input wire logic       tx_fbit_off,
  input wire logic       tx_code_bit,
  input wire logic       tx_code_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire ctl_wr = reg_wr && reg_addr == tlb_pkg::ADDR_CTRL;
  wire msk_wr = reg_wr && reg_addr == tlb_pkg::ADDR_MASK;
  a_rdata_idle: assert property ( // read data only after a read
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not zero");
  a_rd_unmapped: assert property ( // unmapped read
    reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_link_bit_hold: assert property (
    !tx_link_req && !tx_mf_boundary |=> $stable(tx_link_bit)) else $error("link bit moved");
  a_code_bit_hold: assert property (
    !tx_line_stb |=> $stable(tx_code_bit)) else $error("code bit moved");
  // a fresh control write may still be landing, so that strobe is skipped
  a_fbit_insert: assert property (
    tx_line_stb && tx_fbit_pos && !tx_fbit_off && tx_code_active && !$past(ctl_wr)
    |=> tx_code_bit == $past(tx_fbit_val)) else $error("framing bit not inserted");
  a_int_masked: assert property (
    msk_wr && reg_wdata == 8'h00 |-> ##2 int_n) else $error("interrupt with mask clear");
  a_tx_source_lvl: assert property (
    ctl_wr |=> tx_link_legacy == $past(reg_wdata[3])
    && tx_fs_from_link == !$past(reg_wdata[2])) else $error("source levels wrong");
  a_loop_enable_lvl: assert property (
    ctl_wr |=> tx_code_active == $past(reg_wdata[1])) else $error("loop level wrong");
  c_int_low: cover property ($fell(int_n));
  c_fbit_slot: cover property (tx_line_stb && tx_fbit_pos && !tx_fbit_off);
  c_link_slot: cover property (tx_link_req && tx_link_legacy);
endmodule
bind tlb_core tlb_core_sva chk_u (.*);

// ### tb/tlb_line_model.sv
// t1 line side: link bit strobes, slot requests, line bit times.
// assumes the bench loads receive words; transmit code loops back.
`timescale 1ns/1ps
module tlb_line_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // bench control
  input  wire logic [15:0] rx_word,
  input  wire logic [4:0]  rx_len,
  input  wire logic        rx_go,
  input  wire logic        tx_en,
  // from the block
  input  wire logic        tx_link_bit,
  input  wire logic        tx_code_bit,
  // to the block
  output logic             rx_link_bit,
  output logic             rx_link_stb,
  output logic             rx_line_bit,
  output logic             rx_line_stb,
  output logic             tx_link_req,
  output logic             tx_line_stb,
  output logic             tx_fbit_pos,
  output logic [7:0]       tx_cap
);
  logic [1:0]  ph_q;
  logic [4:0]  left_q;
  logic [15:0] sh_q;
  logic [7:0]  fcnt_q;
  logic        req_q;
  wire         rx_fire = ph_q == 2'h0 && left_q != 5'h00;
  // code bit settles one cycle after its strobe, so it loops back unregistered
  assign rx_line_bit = tx_code_bit;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ph_q <= 2'h0;
      left_q <= 5'h00;
      sh_q <= 16'h0000;
      fcnt_q <= 8'h00;
      req_q <= 1'b0;
      tx_cap <= 8'h00;
      rx_link_stb <= 1'b0;
      rx_link_bit <= 1'b0;
      rx_line_stb <= 1'b0;
      tx_link_req <= 1'b0;
      tx_line_stb <= 1'b0;
      tx_fbit_pos <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'h1;
      req_q <= tx_link_req;
      rx_line_stb <= tx_line_stb;
      if (req_q) tx_cap <= {tx_link_bit, tx_cap[7:1]};
      tx_link_req <= tx_en && ph_q == 2'h1;
      tx_line_stb <= !ph_q[0];
      if (tx_line_stb) fcnt_q <= (fcnt_q == 8'hC0) ? 8'h00 : fcnt_q + 8'h01;
      tx_fbit_pos <= !ph_q[0] && fcnt_q == 8'h00;
      rx_link_stb <= rx_fire;
      // idle link line shows the inverse, never a stale bit
      rx_link_bit <= rx_fire ? sh_q[0] : ~rx_link_bit;
      if (rx_go) begin
        sh_q <= rx_word;
        left_q <= rx_len;
      end else if (rx_fire) begin
        sh_q <= sh_q >> 1;
        left_q <= left_q - 5'h01;
      end
    end
  end
endmodule

// ### tb/t1_link_byte_and_loop_code_bench.sv
// self-checking bench for the link byte path and loop-code logic.
// assumes tlb_core, its package and the line model are compiled first.
`timescale 1ns/1ps
module t1_link_byte_and_loop_code_bench;
  localparam int INTEG = 2000;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        tx_fbit_val = 1'b1;
  logic        tx_fbit_off = 1'b1;
  logic        tx_en = 1'b0;
  logic        tx_mf_boundary = 1'b0;
  logic        rx_go = 1'b0;
  logic [15:0] rx_word = 16'h0000;
  logic [4:0]  rx_len = 5'h00;
  logic [7:0]  reg_rdata, tx_cap, rv;
  logic        int_n, rx_link_bit, rx_link_stb, rx_line_bit, rx_line_stb;
  logic        tx_link_req, tx_link_bit, tx_line_stb, tx_fbit_pos, tx_code_bit;
  logic        req_d = 1'b0;
  int          fails = 0, comparisons = 0, run = 0, maxr = 0;
  always #5 clk = ~clk;
  tlb_core #(.INTEG_CYCLES(INTEG)) dut_u (.*, .tx_link_legacy(),
    .tx_fs_from_link(), .tx_code_active());
  tlb_line_model line_u (.*);
  // longest run of ones seen in the sent link slots
  always @(posedge clk) begin
    req_d <= tx_link_req;
    if (req_d) run <= tx_link_bit ? run + 1 : 0;
    if (run > maxr) maxr <= run;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk(rv & m, e);
  endtask
  task automatic send(input logic [15:0] w, input logic [4:0] n);
    @(posedge clk);
    rx_word <= w;
    rx_len <= n;
    rx_go <= 1'b1;
    @(posedge clk);
    rx_go <= 1'b0;
    repeat (4 * n + 6) @(posedge clk);
  endtask
  task automatic wait_int();
    repeat (2) @(posedge clk);
    for (int i = 0; i < 400 && int_n !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk({7'h00, int_n}, 8'h00);
  endtask
  task automatic next_bit(output logic v);
    do begin
      @(posedge clk);
      #1;
    end while (tx_line_stb !== 1'b1);
    @(posedge clk);
    #1 v = tx_code_bit;
  endtask
  task automatic t_regs();
    logic [7:0] a [7] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h29, 8'h2A, 8'h7E};
    chk({7'h00, int_n}, 8'h01);
    foreach (a[i]) rdm(a[i], 8'hFF, 8'h00);
    foreach (a[i]) wr(a[i], 8'hA0 + 8'(i));
    foreach (a[i]) rdm(a[i], 8'hFF, 8'hA0 + 8'(i));
    wr(8'h28, 8'hFF);
    rdm(8'h28, 8'hFF, 8'h00);
    rdm(8'h00, 8'hFF, 8'h00);
    wr(8'h62, 8'h00);
  endtask
  task automatic t_rx();
    wr(8'h29, 8'h11);
    wr(8'h2A, 8'hA5);
    wr(8'h62, 8'h14);
    send(16'h00A5, 5'h08);
    chk({7'h00, int_n}, 8'h00);
    rdm(8'h61, 8'h1C, 8'h14);
    rdm(8'h28, 8'hFF, 8'hA5);
    rdm(8'h61, 8'h1C, 8'h00);
    chk({7'h00, int_n}, 8'h01);
    send(16'h0011, 5'h08);
    rdm(8'h61, 8'h1C, 8'h14);
    send(16'h003C, 5'h08);
    rdm(8'h61, 8'h1C, 8'h10);
    wr(8'h60, 8'h01);
    send(16'h01DF, 5'h09);
    rdm(8'h28, 8'hFF, 8'hFF);
    send(16'h00BF, 5'h08);
    rdm(8'h28, 8'hFF, 8'hBF);
  endtask
  task automatic t_tx();
    wr(8'h7E, 8'h3C);
    wr(8'h60, 8'h08);
    wr(8'h62, 8'h08);
    rdm(8'h61, 8'h1C, 8'h10);
    tx_en <= 1'b1;
    wait_int();
    rdm(8'h61, 8'h08, 8'h08);
    wait_int();
    repeat (3) @(posedge clk);
    chk(tx_cap, 8'h3C);
    rdm(8'h61, 8'h08, 8'h08);
    wait_int();
    repeat (3) @(posedge clk);
    chk(tx_cap, 8'h3C);
    wr(8'h7E, 8'hFF);
    wr(8'h60, 8'h18);
    repeat (100) @(posedge clk);
    maxr = 0;
    repeat (240) @(posedge clk);
    chk(8'(maxr), 8'h05);
    tx_en <= 1'b0;
  endtask
  task automatic t_d4();
    wr(8'h7E, 8'h1C);
    wr(8'h60, 8'h28);
    @(posedge clk);
    tx_mf_boundary <= 1'b1;
    @(posedge clk);
    tx_mf_boundary <= 1'b0;
    rdm(8'h61, 8'h1C, 8'h08);
    tx_en <= 1'b1;
    wait_int();
    repeat (3) @(posedge clk);
    chk(tx_cap, 8'h1C);
    tx_en <= 1'b0;
  endtask
  task automatic t_loop();
    logic [29:0] b;
    logic [7:0]  ones, bad;
    int          p;
    tx_fbit_off <= 1'b1;
    wr(8'h13, 8'h80);
    wr(8'h60, 8'h02);
    for (int l = 0; l < 4; l++) begin
      wr(8'h12, 8'(l << 6));
      p = 5 + l;
      ones = 8'h00;
      bad = 8'h00;
      // a length change may leave the pointer mid-pattern, so skip a few bits
      for (int k = -12; k < 30; k++) begin
        next_bit(b[k < 0 ? 0 : k]);
      end
      for (int k = 0; k < 30; k++) begin
        if (k < p) ones = ones + 8'(b[k]);
        if (k + p < 30) bad = bad | 8'(b[k] ^ b[k + p]);
      end
      chk(ones, 8'h01);
      chk(bad, 8'h00);
    end
  endtask
  task automatic t_fbit();
    logic       v;
    logic [7:0] ones;
    wr(8'h13, 8'h00);
    for (int off = 0; off < 2; off++) begin
      tx_fbit_off <= 1'(off);
      ones = 8'h00;
      for (int k = -10; k < 386; k++) begin
        next_bit(v);
        if (k >= 0) ones = ones + 8'(v);
      end
      chk(ones, off ? 8'h00 : 8'h02);
    end
  endtask
  task automatic t_detect();
    wr(8'h13, 8'h80);
    wr(8'h14, 8'h80);
    wr(8'h15, 8'hFF);
    wr(8'h12, 8'h27);
    tx_fbit_off <= 1'b0;
    repeat (4 * INTEG) @(posedge clk);
    rdm(8'h61, 8'hC0, 8'h80);
    repeat (2 * INTEG) @(posedge clk);
    rdm(8'h61, 8'hC0, 8'h80);
    wr(8'h62, 8'h00);
  endtask
  task automatic summarize();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_rx();
    t_tx();
    t_d4();
    t_loop();
    t_fbit();
    t_detect();
    summarize();
  end
  initial begin
    #300000;
    fails++;
    summarize();
  end
endmodule
